/* rtl/uart_rx_defines.vh */
// constants for the channel a receive error status block
`ifndef UART_RX_DEFINES_VH
`define UART_RX_DEFINES_VH
// word indices on haddr[7:2]
`define IDX_DATA     6'h00
`define IDX_STATUS   6'h01
`define IDX_CMD      6'h02
`define IDX_MODE     6'h03
`define IDX_ISR      6'h04
`define IDX_IMR      6'h05
// command field sits in write data bits 7:4
`define CMD_LSB      4
`define CMD_RST_RX   4'h2
`define CMD_RST_ERR  4'h4
`define CMD_RST_BRK  4'h5
// mode register fields
`define MODE_BLOCK   0
`define MODE_PAR_LSB 1
`define MODE_PAR_SEL 3
`define MODE_LEN_LSB 4
`define MODE_RESET   8'h30
`define PAR_WITH     2'h0
`define PAR_FORCE    2'h1
`define PAR_NONE     2'h2
`define PAR_MDROP    2'h3
// interrupt status bits
`define ISR_BRK      0
`define ISR_RXRDY    1
`define ISR_OVR      2
// timing: 16x oversampling from the system clock
`define CLK_HZ       10000000
`define BAUD_HZ      9600
`define TICK_DIV     (`CLK_HZ / (`BAUD_HZ * 16))
`define HALF_BIT     4'h7
`define LAST_TICK    4'hF
`define FIFO_DEPTH   5'h10
`endif

/* rtl/rx_fifo_mem.v */
// receive fifo storage with registered read data
`timescale 1ns/1ns
module rx_fifo_mem #(
    parameter W  = 11,
    parameter AW = 4
) (
    input  wire          clk_i,
    input  wire          we_i,
    input  wire [AW-1:0] waddr_i,
    input  wire [W-1:0]  wdata_i,
    input  wire [AW-1:0] raddr_i,
    output reg  [W-1:0]  rdata_o
);
    reg [W-1:0] mem [0:(1<<AW)-1];  // character plus its flags

    // write port and read-through register
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;  // head written this cycle
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

/* rtl/uart_rx_error_status.v */
// channel a receiver with per-character error status and ahb-lite registers
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ns
`include "uart_rx_defines.vh"
module uart_rx_error_status (
    input  wire        CLK_I,
    input  wire        RST_I,
    input  wire        HSEL_I,
    input  wire [7:0]  HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output reg  [31:0] HRDATA_O,
    output reg         HREADYOUT_O,
    output reg         HRESP_O,
    input  wire        SERIAL_RX_LINE_A_I,
    input  wire        TX_EMPTY_FLAG_A_I,
    input  wire        TX_READY_FLAG_A_I,
    output reg         IRQ_O
);
    localparam S_IDLE  = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA  = 3'h2;
    localparam S_PAR   = 3'h3;
    localparam S_STOP  = 3'h4;
    localparam S_BRK   = 3'h5;
    localparam integer TDIV_INT = `TICK_DIV;      // system clocks per 16x tick, full width
    localparam [6:0]   TDIV     = TDIV_INT[6:0];  // cut to the divider width on purpose

    // line synchroniser
    reg        rx_s1_reg;            // first stage, read only by second
    reg        rx_reg;               // synchronised line
    // oversampling
    reg [6:0]  div_reg;              // system clocks per 16x tick
    reg        tick_reg;             // one 16x tick
    // receiver
    reg [2:0]  state_reg;            // receiver state
    reg [3:0]  sub_reg;              // ticks within a bit
    reg [2:0]  bitn_reg;             // data bit index
    reg [7:0]  sh_reg;               // shift register
    reg        par_reg;              // received parity bit
    // waiting character in shift stage
    reg        hold_v_reg;           // a character waits for room
    reg [10:0] hold_reg;             // {brk, fe, pe, data}
    // fifo control
    reg [3:0]  wr_ptr_reg;           // write pointer
    reg [3:0]  rd_ptr_reg;           // read pointer
    reg [4:0]  cnt_reg;              // entries held
    reg [4:0]  kill_reg;             // entries whose flags were reset
    reg [2:0]  acc_reg;              // block mode accumulated flags
    reg        ovr_reg;              // overrun flag
    // software registers
    reg [7:0]  mode_reg;             // format and error mode
    reg [2:0]  isr_reg;              // sticky events
    reg [2:0]  imr_reg;              // interrupt mask
    // bus data phase
    reg        wr_ph_reg;            // write data phase pending
    reg [5:0]  wr_idx_reg;           // write word index
    // combinational
    reg        done;                 // character completed at stop middle
    reg [10:0] newc;                 // completed character with flags
    reg        brk_end;              // end of break seen
    reg        push;                 // write into fifo
    reg [10:0] push_d;               // data written
    reg        pop;                  // head read by software
    reg        ovr_set;              // overrun event
    reg [7:0]  status;               // live status byte
    reg [2:0]  head_flags;           // head flags as shown
    reg [7:0]  rdmux;                // read data mux
    reg [7:0]  aligned;              // data aligned to length
    reg        exp_par;              // expected parity
    reg [2:0]  isr_next;             // next interrupt status
    wire [10:0] head;                // head entry
    wire       empty    = (cnt_reg == 5'h00);
    wire       full     = (cnt_reg == `FIFO_DEPTH);
    wire       ahb_go   = HSEL_I & HREADY_I & HTRANS_I[1];
    wire [5:0] a_idx    = HADDR_I[7:2];
    wire       rd_go    = ahb_go & ~HWRITE_I;
    wire [3:0] cmd      = HWDATA_I[`CMD_LSB+3:`CMD_LSB];
    wire       wr_cmd   = wr_ph_reg & (wr_idx_reg == `IDX_CMD);
    wire       rst_rx   = wr_cmd & (cmd == `CMD_RST_RX);
    wire       rst_err  = wr_cmd & (cmd == `CMD_RST_ERR);
    wire       rst_brk  = wr_cmd & (cmd == `CMD_RST_BRK);
    wire [1:0] pmode    = mode_reg[`MODE_PAR_LSB+1:`MODE_PAR_LSB];
    wire [1:0] lenc     = mode_reg[`MODE_LEN_LSB+1:`MODE_LEN_LSB];
    wire [2:0] last_bit = {1'b1, lenc};
    wire [3:0] rd_ptr_next = pop ? rd_ptr_reg + 4'h1 : rd_ptr_reg;

    // fifo storage
    rx_fifo_mem #(
        .W  (11),
        .AW (4)
    ) u_mem (
        .clk_i   (CLK_I),
        .we_i    (push),
        .waddr_i (wr_ptr_reg),
        .wdata_i (push_d),
        .raddr_i (rd_ptr_next),
        .rdata_o (head)
    );

    // two flip-flop synchroniser and 16x tick
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_s1_reg <= 1'b1;
            rx_reg    <= 1'b1;
            div_reg   <= 7'h00;
            tick_reg  <= 1'b0;
        end else begin
            rx_s1_reg <= SERIAL_RX_LINE_A_I;
            rx_reg    <= rx_s1_reg;
            tick_reg  <= (div_reg == TDIV - 7'h01);
            if (div_reg == TDIV - 7'h01) begin
                div_reg <= 7'h00;
            end else begin
                div_reg <= div_reg + 7'h01;
            end
        end
    end

    // character completion, flag building
    always @* begin
        aligned = sh_reg >> (3'h3 - {1'b0, lenc});
        exp_par = (pmode == `PAR_FORCE) ? mode_reg[`MODE_PAR_SEL]
                                        : (^aligned) ^ mode_reg[`MODE_PAR_SEL];
        done    = tick_reg & (state_reg == S_STOP) & (sub_reg == `LAST_TICK);
        newc[7:0] = aligned;
        newc[10] = (aligned == 8'h00) & ~rx_reg & ((pmode == `PAR_NONE) | ~par_reg);
        newc[9]  = ~rx_reg;
        if (pmode == `PAR_MDROP) begin
            newc[8] = par_reg;
        end else if (pmode == `PAR_NONE) begin
            newc[8] = 1'b0;
        end else begin
            newc[8] = par_reg ^ exp_par;
        end
        brk_end = tick_reg & (state_reg == S_BRK) & rx_reg & (sub_reg == `HALF_BIT);
    end

    // receiver state machine
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= S_IDLE;
            sub_reg   <= 4'h0;
            bitn_reg  <= 3'h0;
            sh_reg    <= 8'h00;
            par_reg   <= 1'b0;
        end else if (rst_rx) begin
            state_reg <= S_IDLE;
            sub_reg   <= 4'h0;
        end else if (tick_reg) begin
            sub_reg <= sub_reg + 4'h1;
            case (state_reg)
                S_IDLE: begin
                    // wait for a falling line
                    // low line restarts at once
                    sub_reg <= 4'h0;
                    if (!rx_reg) begin
                        state_reg <= S_START;
                    end
                end
                S_START: begin
                    // middle of start bit rejects glitches
                    if (sub_reg == `HALF_BIT) begin
                        sub_reg   <= 4'h0;
                        bitn_reg  <= 3'h0;
                        state_reg <= rx_reg ? S_IDLE : S_DATA;
                    end
                end
                S_DATA: begin
                    // sample each data bit at its middle
                    if (sub_reg == `LAST_TICK) begin
                        sh_reg   <= {rx_reg, sh_reg[7:1]};
                        bitn_reg <= bitn_reg + 3'h1;
                        if (bitn_reg == last_bit) begin
                            state_reg <= (pmode == `PAR_NONE) ? S_STOP : S_PAR;
                        end
                    end
                end
                S_PAR: begin
                    // parity or address/data bit
                    if (sub_reg == `LAST_TICK) begin
                        par_reg   <= rx_reg;
                        state_reg <= S_STOP;
                    end
                end
                S_STOP: begin
                    // check at first stop bit middle
                    if (sub_reg == `LAST_TICK) begin
                        sub_reg   <= 4'h0;
                        state_reg <= newc[10] ? S_BRK : S_IDLE;
                    end
                end
                S_BRK: begin
                    // half bit of marking ends inhibit
                    if (!rx_reg) begin
                        sub_reg <= 4'h0;
                    end else if (sub_reg == `HALF_BIT) begin
                        state_reg <= S_IDLE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // fifo write and overrun decisions
    always @* begin
        pop     = rd_go & (a_idx == `IDX_DATA) & ~empty;
        push    = 1'b0;
        push_d  = newc;
        ovr_set = 1'b0;
        if (hold_v_reg && !full) begin
            push   = 1'b1;
            push_d = hold_reg;
        end else if (done && !full) begin
            push = 1'b1;
        end
        // new character while full and waiting
        if (done && full && hold_v_reg) begin
            ovr_set = 1'b1;
        end
    end

    // fifo pointers, waiting character, error flags
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            cnt_reg    <= 5'h00;
            kill_reg   <= 5'h00;
            hold_v_reg <= 1'b0;
            hold_reg   <= 11'h000;
            acc_reg    <= 3'h0;
            ovr_reg    <= 1'b0;
        end else if (rst_rx) begin
            // receiver reset empties and clears all error state except the interrupt status bits
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            cnt_reg    <= 5'h00;
            kill_reg   <= 5'h00;
            hold_v_reg <= 1'b0;
            acc_reg    <= 3'h0;
            ovr_reg    <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_reg + {4'h0, push} - {4'h0, pop};
            // shift stage keeps the newest waiting character
            if (done && (full || hold_v_reg)) begin
                hold_v_reg <= 1'b1;
                hold_reg   <= newc;
            end else if (push) begin
                hold_v_reg <= 1'b0;
            end
            // error reset clears break, parity, overrun
            if (rst_err) begin
                kill_reg <= cnt_reg - {4'h0, pop};
                acc_reg  <= push ? push_d[10:8] : 3'h0;
                ovr_reg  <= ovr_set;
                hold_reg[10:8] <= (done && (full || hold_v_reg)) ? newc[10:8] : 3'h0;
            end else begin
                // dropped flags follow the read pointer
                if (pop && kill_reg != 5'h00) begin
                    kill_reg <= kill_reg - 5'h01;
                end
                if (push) begin
                    acc_reg <= acc_reg | push_d[10:8];
                end
                if (ovr_set) begin
                    ovr_reg <= 1'b1;
                end
            end
        end
    end

    // status byte and read mux
    always @*  begin
        // reset flags hidden for old entries
        head_flags = (empty || kill_reg != 5'h00) ? 3'h0 : head[10:8];
        // head flags, or accumulated flags in block mode, with live low bits
        // bit layout of the status byte
        status = {(mode_reg[`MODE_BLOCK] ? acc_reg : head_flags), ovr_reg,
                  TX_EMPTY_FLAG_A_I, TX_READY_FLAG_A_I, full, ~empty};
        case (a_idx)
            `IDX_DATA:   rdmux = empty ? 8'h00 : head[7:0];
            `IDX_STATUS: rdmux = status;
            `IDX_MODE:   rdmux = mode_reg;
            `IDX_ISR:    rdmux = {5'h00, isr_reg};
            `IDX_IMR:    rdmux = {5'h00, imr_reg};
            default:     rdmux = 8'h00;
        endcase
    end

    // interrupt status: set wins over clear
    always @* begin
        isr_next = isr_reg;
        if (wr_ph_reg && wr_idx_reg == `IDX_ISR) begin
            isr_next = isr_next & ~HWDATA_I[2:0];
        end
        if (rst_brk) begin
            isr_next[`ISR_BRK] = 1'b0;
        end
        if ((push && push_d[10]) || brk_end) begin
            isr_next[`ISR_BRK] = 1'b1;
        end
        if (push) begin
            isr_next[`ISR_RXRDY] = 1'b1;
        end
        if (ovr_set) begin
            isr_next[`ISR_OVR] = 1'b1;
        end
    end

    // bus slave and software registers
    always @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            HRDATA_O    <= 32'h00000000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            IRQ_O       <= 1'b0;
            wr_ph_reg   <= 1'b0;
            wr_idx_reg  <= 6'h00;
            mode_reg    <= `MODE_RESET;
            isr_reg     <= 3'h0;
            imr_reg     <= 3'h0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            wr_ph_reg   <= ahb_go & HWRITE_I;
            wr_idx_reg  <= a_idx;
            if (rd_go) begin
                HRDATA_O <= {24'h000000, rdmux};
            end
            // status index absent from write decode
            if (wr_ph_reg) begin
                case (wr_idx_reg)
                    `IDX_MODE: mode_reg <= HWDATA_I[7:0];
                    `IDX_IMR:  imr_reg  <= HWDATA_I[2:0];
                    default:   mode_reg <= mode_reg;
                endcase
            end
            isr_reg <= isr_next;
            IRQ_O   <= |(isr_next & imr_reg);
        end
    end
endmodule

/* bench/uart_rx_status_sva.sv */
// bus and status assertions for the receive error status block
`timescale 1ns/1ns
`include "uart_rx_defines.vh"
module uart_rx_status_sva (
    input wire        CLK_I,
    input wire        RST_I,
    input wire        HSEL_I,
    input wire [7:0]  HADDR_I,
    input wire [1:0]  HTRANS_I,
    input wire        HWRITE_I,
    input wire        HREADY_I,
    input wire [31:0] HRDATA_O,
    input wire        HREADYOUT_O,
    input wire        HRESP_O,
    input wire        TX_EMPTY_FLAG_A_I,
    input wire        TX_READY_FLAG_A_I,
    input wire        IRQ_O
);
    wire rd_any    = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I; // read taken at this edge
    wire rd_status = rd_any & (HADDR_I[7:2] == `IDX_STATUS);      // status read taken
    wire rd_isr    = rd_any & (HADDR_I[7:2] == `IDX_ISR);         // interrupt status read
    wire rd_unmap  = rd_any & (HADDR_I[7:2] > `IDX_IMR);          // read past the map
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_okay_resp: assert property (HRESP_O == 1'b0)
        else $error("response not okay");
    a_zero_wait: assert property (HREADYOUT_O == 1'b1)
        else $error("wait state inserted");
    a_status_tx_bits: assert property (
        rd_status |=> HRDATA_O[3:2] == {$past(TX_EMPTY_FLAG_A_I), $past(TX_READY_FLAG_A_I)})
        else $error("tx flags misplaced in status");
    a_status_upper: assert property (rd_status |=> HRDATA_O[31:8] == 24'h000000)
        else $error("status upper bits set");
    a_full_nonempty: assert property (rd_status |=> !(HRDATA_O[1] && !HRDATA_O[0]))
        else $error("full flag without ready flag");
    a_isr_upper: assert property (rd_isr |=> HRDATA_O[31:3] == 29'h0)
        else $error("isr unused bits set");
    a_unmap_zero: assert property (rd_unmap |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!rd_any |=> $stable(HRDATA_O))
        else $error("read data moved without read");
    c_break_seen: cover property (rd_status ##1 HRDATA_O[7]);
    c_parity_seen: cover property (rd_status ##1 HRDATA_O[5]);
    c_irq_rose: cover property ($rose(IRQ_O));
endmodule

/* bench/serial_tx_model.sv */
// remote asynchronous transmitter model driving the receive line
`timescale 1ns/1ns
`include "uart_rx_defines.vh"
module serial_tx_model (
    input  wire clk_i,
    output reg  line_o
);
    localparam integer BIT_CLKS = 16 * `TICK_DIV; // clocks in one bit cell
    // line idles at marking
    initial begin
        line_o = 1'b1;
    end
    // one bit cell, launched just after a clock edge
    task send_bit(input b);
        begin
            @(posedge clk_i);
            line_o <= b;
            repeat (BIT_CLKS - 1) @(posedge clk_i);
        end
    endtask
    // start, data lsb first, parity, stop, then one marking cell
    task send_char(input [7:0] d, input integer n, input par, input stop);
        integer i;
        begin
            send_bit(1'b0);
            for (i = 0; i < n; i = i + 1)
                send_bit(d[i]);
            send_bit(par);
            send_bit(stop);
            send_bit(1'b1);
        end
    endtask
    // spacing held with no stop bit
    task space_begin;
        begin
            @(posedge clk_i);
            line_o <= 1'b0;
        end
    endtask
    // marking held a full cell, beyond half a bit
    task space_end;
        begin
            send_bit(1'b1);
        end
    endtask
endmodule

/* bench/uart_rx_error_status_tb.sv */
// self-checking bench for the channel a receive error status block
`timescale 1ns/1ns
`include "uart_rx_defines.vh"
module uart_rx_error_status_tb;
    localparam [7:0] A_DATA = {`IDX_DATA, 2'b00};   // byte addresses, one word each
    localparam [7:0] A_STAT = {`IDX_STATUS, 2'b00};
    localparam [7:0] A_CMD  = {`IDX_CMD, 2'b00};
    localparam [7:0] A_MODE = {`IDX_MODE, 2'b00};
    localparam [7:0] A_ISR  = {`IDX_ISR, 2'b00};
    localparam [7:0] A_IMR  = {`IDX_IMR, 2'b00};
    localparam integer BIT_CLKS = 16 * `TICK_DIV;  // clocks in one bit cell
    reg         clk = 1'b0;       // system clock
    reg         rst;              // async reset
    reg         hsel;             // bus select
    reg  [7:0]  haddr;            // bus address
    reg  [1:0]  htrans;           // transfer type
    reg         hwrite;           // write strobe
    reg  [31:0] hwdata;           // write data
    reg         tx_empty;         // live transmitter flags
    reg         tx_ready;
    reg  [31:0] rd;               // last read word
    wire [31:0] hrdata;           // read data
    wire        hreadyout;        // slave ready, fed back as hready
    wire        hresp;            // response
    wire        rx_line;          // serial line from the model
    wire        irq;              // interrupt level
    integer     n_errors;         // mismatch count
    integer     samples_checked;  // comparison count
    // 10 MHz clock
    always #50 clk = ~clk;
    uart_rx_error_status uut (
        .CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
        .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
        .SERIAL_RX_LINE_A_I(rx_line), .TX_EMPTY_FLAG_A_I(tx_empty),
        .TX_READY_FLAG_A_I(tx_ready), .IRQ_O(irq)
    );
    serial_tx_model u_tx (
        .clk_i(clk),
        .line_o(rx_line)
    );
    // compare and report
    task check(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // single word transfer: address phase, then data phase
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            do @(posedge clk); while (hreadyout !== 1'b1);
            htrans <= 2'h0;
            hsel <= 1'b0;
            hwdata <= d;
            do @(posedge clk); while (hreadyout !== 1'b1);
            q = hrdata;
        end
    endtask
    // read one register and compare
    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0, rd);
            check(rd, exp);
        end
    endtask
    // poll interrupt status until a bit of m is set, bounded
    task wait_isr(input [31:0] m);
        integer k;
        begin
            rd = 32'h0;
            for (k = 0; k < 20000 && (rd & m) === 32'h0; k = k + 1)
                xfer(1'b0, A_ISR, 32'h0, rd);
            check(rd & m, m);
        end
    endtask
    // verdict and end of run
    task summarize;
        begin
            if (n_errors == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        n_errors = n_errors + 1;
        summarize;
    end
    // main sequence
    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        tx_empty = 1'b1;
        tx_ready = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(A_MODE, 32'h30);
        rd_chk(8'hFC, 32'h0);
        xfer(1'b1, A_MODE, 32'h0, rd);
        xfer(1'b1, A_IMR, 32'h2, rd);
        // clean char, then wrong parity, then spacing stop bit
        u_tx.send_char(8'h15, 5, 1'b1, 1'b1);
        wait_isr(32'h2);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, A_IMR, 32'h0, rd);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        xfer(1'b1, A_ISR, 32'h2, rd);
        xfer(1'b1, A_IMR, 32'h2, rd);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        u_tx.send_char(8'h15, 5, 1'b0, 1'b1);
        wait_isr(32'h2);
        u_tx.send_char(8'h0A, 5, 1'b0, 1'b0);
        wait_isr(32'h2);
        rd_chk(A_STAT, 32'h09);
        rd_chk(A_DATA, 32'h15);
        rd_chk(A_STAT, 32'h29);
        rd_chk(A_DATA, 32'h15);
        rd_chk(A_STAT, 32'h49);
        rd_chk(A_DATA, 32'h0A);
        rd_chk(A_STAT, 32'h08);
        // break in block error mode
        xfer(1'b1, A_MODE, 32'h1, rd);
        xfer(1'b1, A_CMD, 32'h40, rd);
        u_tx.space_begin;
        wait_isr(32'h1);
        rd_chk(A_STAT, 32'hC9);
        xfer(1'b1, A_ISR, 32'h3, rd);
        repeat (2 * BIT_CLKS) @(posedge clk);
        rd_chk(A_ISR, 32'h0);
        u_tx.space_end;
        wait_isr(32'h1);
        xfer(1'b1, A_CMD, 32'h50, rd);
        rd_chk(A_ISR, 32'h0);
        rd_chk(A_STAT, 32'hC9);
        rd_chk(A_DATA, 32'h0);
        rd_chk(A_STAT, 32'hC8);
        u_tx.send_char(8'h15, 5, 1'b0, 1'b1);
        wait_isr(32'h2);
        rd_chk(A_STAT, 32'hE9);
        xfer(1'b1, A_CMD, 32'h40, rd);
        rd_chk(A_STAT, 32'h09);
        xfer(1'b1, A_STAT, 32'hFF, rd);
        tx_ready <= 1'b1;
        rd_chk(A_STAT, 32'h0D);
        rd_chk(A_DATA, 32'h15);
        // force parity at one, character sent with zero
        xfer(1'b1, A_MODE, 32'h0A, rd);
        u_tx.send_char(8'h15, 5, 1'b0, 1'b1);
        rd_chk(A_STAT, 32'h2D);
        rd_chk(A_DATA, 32'h15);
        // multi-drop keeps the address/data bit, then receiver reset empties
        xfer(1'b1, A_MODE, 32'h06, rd);
        u_tx.send_char(8'h15, 5, 1'b1, 1'b1);
        rd_chk(A_STAT, 32'h2D);
        xfer(1'b1, A_CMD, 32'h20, rd);
        rd_chk(A_STAT, 32'h0C);
        rd_chk(A_DATA, 32'h0);
        summarize;
    end
endmodule
bind uart_rx_error_status uart_rx_status_sva u_sva (
    .CLK_I(CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O), .TX_EMPTY_FLAG_A_I(TX_EMPTY_FLAG_A_I), .TX_READY_FLAG_A_I(TX_READY_FLAG_A_I),
    .IRQ_O(IRQ_O)
);
